/* File: logic/serializer_pkg.sv */
// Constants shared by the display serializer and its word buffer
// Behaviour
// - Four independent seven-bit parallel-load shift registers
// - Capture all 28 inputs each active edge unless the word buffer is full
// - Edge select high rising, low falling
// - Seven bit slots per pixel period
// - Four data lanes plus forwarded clock lane
// - Forwarded clock matches pixel clock frequency
// - Shutdown low stops clocking, drivers off
// - Shutdown low asynchronously clears all registers
// - Shutdown low makes every lane high impedance
package serializer_pkg;
    localparam int DATA_BITS   = 28;
    localparam int LANES       = 4;
    localparam int SLICE_BITS  = 7;
    localparam int FIFO_DEPTH  = 4;
    localparam int COUNT_BITS  = 16;
    // Time constants, in their own units
    localparam int CLOCK_PERIOD_NS     = 100;
    localparam int PIXEL_MIN_PERIOD_NS = 800;
    // Least pixel period in system cycles, rounded up
    localparam int PIXEL_MIN_CYCLES =
        (PIXEL_MIN_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Forwarded clock shape over the seven slots, first slot in bit 6
    localparam logic [6:0] CLOCK_PATTERN = 7'h63;
    // Reset values
    localparam logic [6:0]  SHIFT_RESET = 7'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [2:0]  SLOT_RESET  = 3'h0;
    localparam logic [2:0]  SLOT_LAST   = 3'h6;
endpackage

/* File: logic/word_fifo.sv */
// Small flip-flop FIFO holding captured pixel words
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clear_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    // Pointer wrap shared by both ends
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    // Handshakes on both sides
    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    // Storage, cleared by shutdown
    always_ff @(posedge clock or negedge clear_n) begin
        if (!clear_n) begin
            for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
        end else if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clock or negedge clear_n) begin
        if (!clear_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end
endmodule // word_fifo

/* File: logic/lvds_display_serializer.sv */
// Display serializer: 28-bit pixel capture, four lanes plus clock
`timescale 1ns/1ps
module lvds_display_serializer #(
    parameter int DATA_BITS  = serializer_pkg::DATA_BITS,
    parameter int FIFO_DEPTH = serializer_pkg::FIFO_DEPTH
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 pixel_clock_in,
    input  wire logic                 capture_edge_select,
    input  wire logic                 shutdown_n,
    input  wire logic [DATA_BITS-1:0] parallel_data,
    output logic [3:0]                serial_lane_pos,
    output logic [3:0]                serial_lane_neg,
    output logic [3:0]                serial_lane_oe,
    output logic                      forwarded_clock_out_pos,
    output logic                      forwarded_clock_out_neg,
    output logic                      forwarded_clock_out_oe,
    output logic                      capture_dropped
);
    localparam int CW = serializer_pkg::COUNT_BITS;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic                 clk_meta_reg;
    logic                 clk_sync_reg;
    logic                 clk_prev_reg;
    logic                 sel_meta_reg;
    logic                 sel_sync_reg;
    logic [DATA_BITS-1:0] data_meta_reg;
    logic [DATA_BITS-1:0] data_sync_reg;
    logic                 run_meta_reg;
    logic                 run_reg;
    logic                 capture_edge;
    logic [CW-1:0]        period_cnt_reg;
    logic [CW-1:0]        period_reg;
    logic [CW-1:0]        acc_reg;
    logic [CW:0]          acc_next;
    logic                 slot_tick;
    logic [2:0]           slot_reg;
    logic [6:0]           shift_reg [4];
    logic [6:0]           new_slice [4];
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_pop;
    logic [DATA_BITS-1:0] fifo_out_data;
    logic [3:0]           lane_bit_reg;
    logic                 clk_bit_reg;
    logic [3:0]           lane_neg_reg;
    logic                 clk_neg_reg;
    logic                 drive_reg;
    logic                 dropped_reg;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Forwarded clock level for a slot, first slot in the top bit
    function automatic logic clock_shape(input logic [2:0] slot);
        return serializer_pkg::CLOCK_PATTERN[
            serializer_pkg::SLOT_LAST - slot];
    endfunction

    // Bit that leaves a lane at a tick: a fresh slice or the held one
    function automatic logic lane_head(input logic       pop,
                                       input logic [6:0] fresh,
                                       input logic [6:0] held);
        return pop ? fresh[6] : held[6];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    // Pixel clock, edge select and data each pass two flip-flops
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            clk_meta_reg  <= 1'b0;
            clk_sync_reg  <= 1'b0;
            clk_prev_reg  <= 1'b0;
            sel_meta_reg  <= 1'b0;
            sel_sync_reg  <= 1'b0;
            data_meta_reg <= '0;
            data_sync_reg <= '0;
        end else if (!rst_n) begin
            clk_meta_reg  <= 1'b0;
            clk_sync_reg  <= 1'b0;
            clk_prev_reg  <= 1'b0;
            sel_meta_reg  <= 1'b0;
            sel_sync_reg  <= 1'b0;
            data_meta_reg <= '0;
            data_sync_reg <= '0;
        end else begin
            clk_meta_reg  <= pixel_clock_in;
            clk_sync_reg  <= clk_meta_reg;
            clk_prev_reg  <= clk_sync_reg;
            sel_meta_reg  <= capture_edge_select;
            sel_sync_reg  <= sel_meta_reg;
            data_meta_reg <= parallel_data;
            data_sync_reg <= data_meta_reg;
        end
    end

    // Shutdown release: cleared at once, released after two edges
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            run_meta_reg <= 1'b0;
            run_reg      <= 1'b0;
        end else if (!rst_n) begin
            run_meta_reg <= 1'b0;
            run_reg      <= 1'b0;
        end else begin
            run_meta_reg <= 1'b1;
            run_reg      <= run_meta_reg;
        end
    end

    // Selected pixel clock edge; gated one edge past run so that the
    // edge flop holds a real sample and a high pin is no false edge
    assign capture_edge = drive_reg && (sel_sync_reg ?
        (clk_sync_reg && !clk_prev_reg) :
        (!clk_sync_reg && clk_prev_reg));

    ////////////////////////////////////////////////////////////////////
    // Capture into the word buffer

    word_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_word_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .clear_n   (shutdown_n),
        .in_valid  (capture_edge),
        .in_ready  (fifo_in_ready),
        .in_data   (data_sync_reg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // Sticky flag: a word arrived while the buffer was full
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            dropped_reg <= 1'b0;
        end else if (!rst_n) begin
            dropped_reg <= 1'b0;
        end else if (capture_edge && !fifo_in_ready) begin
            dropped_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit slot timing: seven slots per measured pixel period

    // Pixel period in system cycles, measured edge to edge
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            period_cnt_reg <= serializer_pkg::COUNT_RESET;
            period_reg     <= serializer_pkg::COUNT_RESET;
        end else if (!rst_n) begin
            period_cnt_reg <= serializer_pkg::COUNT_RESET;
            period_reg     <= serializer_pkg::COUNT_RESET;
        end else if (!run_reg) begin
            period_cnt_reg <= serializer_pkg::COUNT_RESET;
            period_reg     <= serializer_pkg::COUNT_RESET;
        end else if (capture_edge) begin
            period_reg     <= period_cnt_reg + 1'b1;
            period_cnt_reg <= serializer_pkg::COUNT_RESET;
        end else if (period_cnt_reg != {CW{1'b1}}) begin
            period_cnt_reg <= period_cnt_reg + 1'b1;
        end
    end

    // Accumulator adds seven per cycle, ticks each period-th part
    assign acc_next  = {1'b0, acc_reg} +
                       (CW+1)'(serializer_pkg::SLICE_BITS);
    assign slot_tick = run_reg && (period_reg != '0) &&
                       (acc_next >= {1'b0, period_reg});

    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            acc_reg <= serializer_pkg::COUNT_RESET;
        end else if (!rst_n || !run_reg || period_reg == '0) begin
            acc_reg <= serializer_pkg::COUNT_RESET;
        end else if (slot_tick) begin
            acc_reg <= CW'(acc_next - {1'b0, period_reg});
        end else begin
            acc_reg <= acc_next[CW-1:0];
        end
    end

    // Slot index 0..6 within the pixel period
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            slot_reg <= serializer_pkg::SLOT_RESET;
        end else if (!rst_n || !run_reg) begin
            slot_reg <= serializer_pkg::SLOT_RESET;
        end else if (slot_tick) begin
            slot_reg <= (slot_reg == serializer_pkg::SLOT_LAST) ?
                serializer_pkg::SLOT_RESET : slot_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lane shift registers

    // Lane k carries bits 7k+6 down to 7k, highest bit first
    always_comb begin
        for (int k = 0; k < serializer_pkg::LANES; k++) begin
            new_slice[k] = fifo_out_valid ?
                fifo_out_data[k*7 +: 7] :
                serializer_pkg::SHIFT_RESET;
        end
    end

    // A new word is taken at the first slot of each period
    assign fifo_pop = slot_tick &&
                      (slot_reg == serializer_pkg::SLOT_RESET);

    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            for (int k = 0; k < 4; k++) begin
                shift_reg[k] <= serializer_pkg::SHIFT_RESET;
            end
            lane_bit_reg <= 4'h0;
        end else if (!rst_n || !run_reg) begin
            for (int k = 0; k < 4; k++) begin
                shift_reg[k] <= serializer_pkg::SHIFT_RESET;
            end
            lane_bit_reg <= 4'h0;
        end else if (slot_tick) begin
            for (int k = 0; k < 4; k++) begin
                if (fifo_pop) begin
                    lane_bit_reg[k] <= new_slice[k][6];
                    shift_reg[k]    <= {new_slice[k][5:0], 1'b0};
                end else begin
                    lane_bit_reg[k] <= shift_reg[k][6];
                    shift_reg[k]    <= {shift_reg[k][5:0], 1'b0};
                end
            end
        end
    end

    // Forwarded clock follows the fixed seven-slot shape
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            clk_bit_reg <= 1'b0;
        end else if (!rst_n || !run_reg) begin
            clk_bit_reg <= 1'b0;
        end else if (slot_tick) begin
            clk_bit_reg <= clock_shape(slot_reg);
        end
    end

    // Lane complements, kept in flip-flops so no pin leaves a gate
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            lane_neg_reg <= 4'h0;
        end else if (!rst_n || !run_reg) begin
            lane_neg_reg <= 4'h0;
        end else if (slot_tick) begin
            for (int k = 0; k < 4; k++) begin
                lane_neg_reg[k] <= !lane_head(fifo_pop, new_slice[k],
                                              shift_reg[k]);
            end
        end else begin
            lane_neg_reg <= ~lane_bit_reg; // Complement of the held bit
        end
    end

    // Forwarded clock complement, same timing as its true half
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            clk_neg_reg <= 1'b0;
        end else if (!rst_n || !run_reg) begin
            clk_neg_reg <= 1'b0;
        end else if (slot_tick) begin
            clk_neg_reg <= !clock_shape(slot_reg);
        end else begin
            clk_neg_reg <= !clk_bit_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output drivers

    // Drivers on only while running
    always_ff @(posedge clock or negedge shutdown_n) begin
        if (!shutdown_n) begin
            drive_reg <= 1'b0;
        end else if (!rst_n) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= run_reg;
        end
    end

    assign serial_lane_pos         = lane_bit_reg;
    assign serial_lane_neg         = lane_neg_reg;
    assign serial_lane_oe          = {4{drive_reg}};
    assign forwarded_clock_out_pos = clk_bit_reg;
    assign forwarded_clock_out_neg = clk_neg_reg;
    assign forwarded_clock_out_oe  = drive_reg;
    assign capture_dropped         = dropped_reg;
endmodule // lvds_display_serializer

/* File: tb/serializer_properties.sv */
// Port-level assertions and covers for the display serializer
`timescale 1ns/1ps
module serializer_properties #(
    parameter int DATA_BITS  = 28,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       shutdown_n,
    input wire logic [3:0] serial_lane_pos,
    input wire logic [3:0] serial_lane_neg,
    input wire logic [3:0] serial_lane_oe,
    input wire logic       forwarded_clock_out_pos,
    input wire logic       forwarded_clock_out_neg,
    input wire logic       forwarded_clock_out_oe,
    input wire logic       capture_dropped
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!shutdown_n || !rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Shutdown silences every driver and clears the sticky flag
    a_shutdown_quiet: assert property (disable iff (1'b0)
        !shutdown_n |-> serial_lane_oe == 4'h0 && !forwarded_clock_out_oe
        && serial_lane_pos == 4'h0 && !forwarded_clock_out_pos
        && !capture_dropped) else $error("outputs live in shutdown");
    // Synchronous reset turns the drivers off at the next edge
    a_reset_quiet: assert property (disable iff (!shutdown_n)
        !rst_n |=> serial_lane_oe == 4'h0 && !forwarded_clock_out_oe
        && !capture_dropped) else $error("drivers live after reset");
    // Each pair is complementary while driven, negative half low when off
    a_lane_pairs: assert property (
        serial_lane_neg == (~serial_lane_pos & serial_lane_oe))
        else $error("lane pair not complementary");
    a_clock_pair: assert property (
        forwarded_clock_out_neg ==
        (!forwarded_clock_out_pos && forwarded_clock_out_oe))
        else $error("clock pair not complementary");
    // All five lanes switch on and off together
    a_oe_together: assert property (
        serial_lane_oe == {4{forwarded_clock_out_oe}})
        else $error("lane enables differ");
    // Forwarded clock shape: three low slots, then four high slots
    a_low_run: assert property (disable iff (!shutdown_n || !rst_n)
        $fell(forwarded_clock_out_pos) |->
        !forwarded_clock_out_pos [*3] ##[1:3] forwarded_clock_out_pos)
        else $error("clock low phase wrong");
    a_high_run: assert property (disable iff (!shutdown_n || !rst_n)
        $fell(forwarded_clock_out_pos) ##1 !forwarded_clock_out_pos [*2]
        ##[1:2] $rose(forwarded_clock_out_pos) |->
        forwarded_clock_out_pos [*4] ##[1:3] !forwarded_clock_out_pos)
        else $error("clock high phase wrong");
    // One forwarded clock period per pixel period
    a_period_match: assert property (disable iff (!shutdown_n || !rst_n)
        $fell(forwarded_clock_out_pos) |=>
        !$fell(forwarded_clock_out_pos) [*6] ##[1:9]
        $fell(forwarded_clock_out_pos)) else $error("clock period wrong");
    // Main scenarios reached
    c_dropped: cover property ($rose(capture_dropped));
    c_clock: cover property ($fell(forwarded_clock_out_pos));
    c_off: cover property (disable iff (1'b0) $fell(shutdown_n));
endmodule // serializer_properties

bind lvds_display_serializer serializer_properties #(
    .DATA_BITS(DATA_BITS), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .clock(clock), .rst_n(rst_n), .shutdown_n(shutdown_n),
    .serial_lane_pos(serial_lane_pos), .serial_lane_neg(serial_lane_neg),
    .serial_lane_oe(serial_lane_oe),
    .forwarded_clock_out_pos(forwarded_clock_out_pos),
    .forwarded_clock_out_neg(forwarded_clock_out_neg),
    .forwarded_clock_out_oe(forwarded_clock_out_oe),
    .capture_dropped(capture_dropped));

/* File: tb/pixel_partner.sv */
// Pixel source and panel-side frame receiver around the serializer
`timescale 1ns/1ps
module pixel_partner (
    input  wire logic       clock,
    input  wire logic       send,
    input  wire logic       mode18,
    input  wire logic       fast,
    input  wire logic       edge_sel,
    input  wire logic [3:0] lane_pos,
    input  wire logic       fwd_pos,
    input  wire logic       fwd_oe,
    output logic            pixel_clock,
    output logic [27:0]     data
);
    localparam logic [27:0] MASK18 = 28'h8830c20;
    logic [27:0] sent_q[$];
    logic [27:0] rcv_q[$];
    int          idx;
    int          cnt;
    logic [4:0]  prev;
    logic [6:0]  sh [4];
    ////////////////////////////////////////////////////////////////////////
    // Free-running pixel clock, phase unrelated to the system clock
    initial begin
        pixel_clock = 1'b0;
        data = 28'h0;
        idx = 0;
        #37;
        forever begin
            #(fast ? 100 : 400);
            pixel_clock = ~pixel_clock;
        end
    end
    // New word on the unused edge, recorded on the capture edge
    always @(pixel_clock) begin
        if (pixel_clock === edge_sel) begin
            if (data[6:0] === 7'h56) sent_q.push_back(data);
        end else begin
            data = send ? {21'h1b3c5a ^ 21'(idx * 21'h0f0f1), 7'h56} : 28'h0;
            if (mode18) data = data & ~MASK18;
            idx++;
        end
    end
    // One distinct lane state per slot; frames align on the clock fall
    always @(negedge clock) begin
        if (!fwd_oe) begin
            prev = 5'h0;
            cnt = 9;
        end else if ({fwd_pos, lane_pos} !== prev) begin
            cnt = (prev[4] && !fwd_pos) ? 0 : cnt + 1;
            prev = {fwd_pos, lane_pos};
            for (int k = 0; k < 4; k++) begin
                sh[k] = {sh[k][5:0], lane_pos[k]};
            end
            if (cnt == 4 && sh[0] === 7'h56)
                rcv_q.push_back({sh[3], sh[2], sh[1], sh[0]});
        end
    end
endmodule // pixel_partner

/* File: tb/test_lvds_display_serializer.sv */
// Self-checking testbench for the display serializer
`timescale 1ns/1ps
module test_lvds_display_serializer;
    logic        clock;
    logic        rst_n;
    logic        shutdown_n;
    logic        edge_sel;
    logic        send;
    logic        mode18;
    logic        fast;
    logic        pclk;
    logic [27:0] pdata;
    logic [3:0]  lp;
    logic [3:0]  ln;
    logic [3:0]  loe;
    logic        cp;
    logic        cn;
    logic        coe;
    logic        dropped;
    int          num_errors;
    int          n_checks;
    ////////////////////////////////////////////////////////////////////////
    // System clock, 100 ns
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    lvds_display_serializer dut_u (.clock(clock), .rst_n(rst_n),
        .pixel_clock_in(pclk), .capture_edge_select(edge_sel),
        .shutdown_n(shutdown_n), .parallel_data(pdata),
        .serial_lane_pos(lp), .serial_lane_neg(ln), .serial_lane_oe(loe),
        .forwarded_clock_out_pos(cp), .forwarded_clock_out_neg(cn),
        .forwarded_clock_out_oe(coe), .capture_dropped(dropped));
    pixel_partner src_u (.clock(clock), .send(send), .mode18(mode18),
        .fast(fast), .edge_sel(edge_sel), .lane_pos(lp), .fwd_pos(cp),
        .fwd_oe(coe), .pixel_clock(pclk), .data(pdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic check_word(input logic [27:0] got, input logic [27:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Shutdown pulse, new capture edge, then time to measure the period
    task automatic restart(input logic sel);
        @(posedge clock);
        shutdown_n <= 1'b0;
        edge_sel <= sel;
        repeat (4) @(posedge clock);
        shutdown_n <= 1'b1;
        repeat (40) @(posedge clock);
    endtask
    // Word stream on one capture edge, received frame by frame
    task automatic t_stream(input logic sel, input logic m18);
        logic [27:0] got;
        restart(sel);
        mode18 <= m18;
        src_u.sent_q.delete();
        src_u.rcv_q.delete();
        send <= 1'b1;
        repeat (80) @(posedge clock);
        send <= 1'b0;
        repeat (60) @(posedge clock);
        check_bit(src_u.sent_q.size() > 6, 1'b1);
        check_word(28'(src_u.rcv_q.size()), 28'(src_u.sent_q.size()));
        while (src_u.rcv_q.size() > 0 && src_u.sent_q.size() > 0) begin
            got = src_u.rcv_q.pop_front();
            check_word(got, src_u.sent_q.pop_front());
            if (m18) check_word(got & 28'h8830c20, 28'h0);
        end
    endtask
    // Shutdown in mid-stream, then recovery of the drivers
    task automatic t_shutdown();
        send <= 1'b1;
        repeat (30) @(posedge clock);
        shutdown_n <= 1'b0;
        #1;
        check_word({loe, ln, lp, coe, cp, cn, dropped}, 28'h0);
        repeat (3) @(posedge clock);
        shutdown_n <= 1'b1;
        repeat (5) @(posedge clock);
        check_word({24'h0, loe}, 28'hf);
        check_bit(coe, 1'b1);
        send <= 1'b0;
    endtask
    // Pixel clock far too fast: the buffer fills and captures drop
    task automatic t_overflow();
        check_bit(dropped, 1'b0);
        fast <= 1'b1;
        repeat (80) @(posedge clock);
        check_bit(dropped, 1'b1);
        fast <= 1'b0;
        repeat (40) @(posedge clock);
        check_bit(dropped, 1'b1);
        restart(1'b1);
        check_bit(dropped, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        num_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        shutdown_n = 1'b1;
        edge_sel = 1'b1;
        send = 1'b0;
        mode18 = 1'b0;
        fast = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (40) @(posedge clock);
        t_stream(1'b1, 1'b0);
        t_stream(1'b0, 1'b0);
        t_stream(1'b1, 1'b1);
        t_shutdown();
        t_overflow();
        complete_run();
    end
    // Watchdog, well beyond the expected run length
    initial begin
        #(3000 * 100);
        num_errors++;
        complete_run();
    end
endmodule // test_lvds_display_serializer
